// File: hw/sewt_pkg.sv
// shared constants and types for the two-wire eeprom write target and its bus master
package sewt_pkg;
  // system clock and self-timed programming time
  localparam int CLK_HZ = 125_000_000;
  localparam int PROG_TIME_MS = 3;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
  // word and page geometry
  localparam int WORD_BITS = 8;
  localparam int PAGE_BYTES = 128;
  localparam int OFS_W = 7;
  localparam int ID_SEL_BIT = 10;
  localparam logic [3:0] DEV_ARRAY = 4'ha;
  localparam logic [3:0] DEV_ID = 4'hb;
  localparam int RECOV_CLOCKS = 9;
  // master timing: one scl period is four quarters of QDIV cycles
  localparam int QDIV = 32;
  // master register map and fields
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CMD_OP_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_RFAIL = 2;
  localparam int ST_SDA = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // master command codes
  typedef enum logic [1:0] {OP_START = 2'b00, OP_STOP = 2'b01, OP_BYTE = 2'b10, OP_RECOV = 2'b11} sewt_op_t;
  // target states and word phases
  typedef enum logic [1:0] {T_IDLE = 2'b00, T_RX = 2'b01, T_ACK = 2'b10, T_PROG = 2'b11} sewt_tst_t;
  typedef enum logic [1:0] {PH_DEV = 2'b00, PH_HI = 2'b01, PH_LO = 2'b10, PH_DATA = 2'b11} sewt_ph_t;
  // master states
  typedef enum logic [2:0] {H_IDLE = 3'b000, H_START = 3'b001, H_STOP = 3'b010, H_BIT = 3'b011,
    H_RECOV = 3'b100} sewt_hst_t;
endpackage

// File: hw/sewt_if.sv
// two-wire bus between master and eeprom target, with pulled-up data line
`timescale 1ns/100ps
interface sewt_if;
  logic scl;
  logic sda;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_t_o;
  logic sda_t_oe;
  // open-drain wired-and with pull-up
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_t_oe & ~sda_t_o));
  modport target(input scl, input sda, output sda_t_o, output sda_t_oe);
  modport master(output scl, input sda, output sda_m_o, output sda_m_oe);
endinterface

// File: hw/sewt_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module sewt_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sewt_sync_t;
  sewt_sync_t r;
  sewt_sync_t next_r;

  // first stage feeds only the second
  always_comb
  begin
    next_r.meta = d;
    next_r.q = r.meta;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.q;
endmodule

// File: hw/sewt_target.sv
// eeprom target end: bus conditions, addressing, byte and page writes, timed programming
// Operation
// - data changes only while clock low
// - falling data, clock high: start, seen except while programming
// - rising data, clock high: stop
// - 8-bit words, acknowledge on ninth clock
// - standby at power-up and after stop
// - master recovers bus with nine clocks, start
// - address word: type, three straps, direction
// - compare straps; open strap reads low
// - direction bit one reads, zero writes; a read is acknowledged, then standby, no data
// - acknowledge match, else back to standby
// - 128-byte pages, two-byte address, high first
// - byte write ends with stop, starts programming
// - ignore bus while programming
// - programming finishes within 3 ms
// - page write increments in-page offset only
// - offset wraps within same page
// - write protect high blocks array writes
// - id page type 1011, select bit zero
// - locked id page: data not acknowledged
// - polling acknowledged only after programming
// - sample on rise, drive after fall
`timescale 1ns/100ps
module sewt_target
  import sewt_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  sewt_if.target bus,
  input wire logic [2:0] strap_address_inputs,
  input wire logic write_protect,
  input wire logic id_locked,
  output logic busy,
  output logic prog_we,
  output logic prog_id,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_data
);
  localparam int TW = $clog2(PROG_CYC + 1);

  typedef struct packed {
    sewt_tst_t st;
    sewt_ph_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [15:0] addr;
    logic is_id;
    logic rd;
    logic loaded;
    logic [PAGE_BYTES-1:0] mask;
    logic [7:0] pidx;
    logic [TW-1:0] timer;
    logic scl_d;
    logic sda_d;
    logic sda_oe;
    logic we;
    logic [15:0] waddr;
    logic [7:0] wdata;
  } sewt_treg_t;

  sewt_treg_t r;
  sewt_treg_t next_r;
  logic [5:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] strap_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic permit;
  logic buf_we;
  logic [OFS_W-1:0] buf_idx;
  logic [7:0] buf_dat;
  logic [7:0] page [PAGE_BYTES];

  // pins cross into the clock domain first
  sewt_sync #(.W(6)) sewt_sync_inst (
    .clk(clk),
    .resetn(resetn),
    .d({bus.scl, bus.sda, write_protect, strap_address_inputs}),
    .q(sync_q)
  );

  assign scl_s = sync_q[5];
  assign sda_s = sync_q[4];
  assign wp_s = sync_q[3];
  assign strap_s = sync_q[2:0];

  // clock edges and bus conditions from synchronised lines
  assign rise = scl_s & ~r.scl_d;
  assign fall = ~scl_s & r.scl_d;
  assign start = scl_s & r.scl_d & r.sda_d & ~sda_s;
  assign stop = scl_s & r.scl_d & ~r.sda_d & sda_s;

  // programming allowed for id page with select bit clear, array when unprotected
  assign permit = r.is_id ? ~r.addr[ID_SEL_BIT] : ~wp_s;

  // next-state logic
  always_comb
  begin
    logic ack;
    ack = 1'b0;
    next_r = r;
    buf_we = 1'b0;
    buf_idx = r.addr[OFS_W-1:0];
    buf_dat = r.sh;
    next_r.scl_d = scl_s;
    next_r.sda_d = sda_s;
    next_r.we = 1'b0;
    unique case (r.st)
      T_IDLE:
      begin
        next_r.sda_oe = 1'b0;
      end
      T_RX:
      begin
        if (rise)
        begin
          next_r.sh = {r.sh[6:0], sda_s};
          next_r.cnt = r.cnt + 4'h1;
        end
        else if (fall && r.cnt == 4'(WORD_BITS))
        begin
          next_r.st = T_IDLE;
          next_r.cnt = 4'h0;
          unique case (r.ph)
            PH_DEV:
            begin
              if ((r.sh[7:4] == DEV_ARRAY || r.sh[7:4] == DEV_ID) && r.sh[3:1] == strap_s)
              begin
                ack = 1'b1;
                next_r.is_id = (r.sh[7:4] == DEV_ID);
                next_r.rd = r.sh[0];
                next_r.ph = PH_HI;
              end
            end
            PH_HI:
            begin
              ack = 1'b1;
              next_r.addr[15:8] = r.sh;
              next_r.ph = PH_LO;
            end
            PH_LO:
            begin
              ack = 1'b1;
              next_r.addr[7:0] = r.sh;
              next_r.ph = PH_DATA;
            end
            PH_DATA:
            begin
              if (!(r.is_id && id_locked))
              begin
                ack = 1'b1;
                buf_we = 1'b1;
                next_r.mask[r.addr[OFS_W-1:0]] = 1'b1;
                next_r.addr[OFS_W-1:0] = r.addr[OFS_W-1:0] + 7'h01;
                next_r.loaded = 1'b1;
              end
            end
          endcase
          if (ack)
          begin
            next_r.st = T_ACK;
            next_r.sda_oe = 1'b1;
          end
        end
      end
      T_ACK:
      begin
        if (fall)
        begin
          next_r.sda_oe = 1'b0;
          next_r.st = r.rd ? T_IDLE : T_RX;
        end
      end
      T_PROG:
      begin
        // bus ignored; buffered bytes go out, then the timer runs out
        next_r.sda_oe = 1'b0;
        next_r.timer = TW'(r.timer + 1'b1);
        if (!r.pidx[7])
        begin
          next_r.we = r.mask[r.pidx[OFS_W-1:0]];
          next_r.waddr = {r.addr[15:7], r.pidx[OFS_W-1:0]};
          next_r.wdata = page[r.pidx[OFS_W-1:0]];
          next_r.pidx = r.pidx + 8'h01;
        end
        if (r.timer == TW'(PROG_CYC - 1))
        begin
          next_r.st = T_IDLE;
          next_r.loaded = 1'b0;
          next_r.mask = '0;
        end
      end
    endcase
    // conditions override every state except programming
    if (r.st != T_PROG)
    begin
      if (start)
      begin
        next_r.st = T_RX;
        next_r.ph = PH_DEV;
        next_r.cnt = 4'h0;
        next_r.sda_oe = 1'b0;
        next_r.rd = 1'b0;
        next_r.loaded = 1'b0;
        next_r.mask = '0;
      end
      else if (stop)
      begin
        next_r.sda_oe = 1'b0;
        if (r.loaded && permit)
        begin
          next_r.st = T_PROG;
          next_r.pidx = 8'h00;
          next_r.timer = '0;
        end
        else
        begin
          next_r.st = T_IDLE;
          next_r.loaded = 1'b0;
          next_r.mask = '0;
        end
      end
    end
  end

  // state register, standby after reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
      r <= '0;
    else
      r <= next_r;
  end

  // page buffer filled by received data bytes
  always_ff @(posedge clk)
  begin
    if (buf_we)
      page[buf_idx] <= buf_dat;
  end

  // outputs
  assign bus.sda_t_o = 1'b0;
  assign bus.sda_t_oe = r.sda_oe;
  assign busy = (r.st == T_PROG);
  assign prog_we = r.we;
  assign prog_id = r.is_id;
  assign prog_addr = r.waddr;
  assign prog_data = r.wdata;
endmodule

// File: hw/sewt_master.sv
// two-wire bus master driven by commands over an axi4-lite register slave
`timescale 1ns/100ps
module sewt_master
  import sewt_pkg::*;
#(
  parameter int QD = QDIV
) (
  input wire logic clk,
  input wire logic resetn,
  sewt_if.master bus,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int DW = $clog2(QD);

  typedef struct packed {
    sewt_hst_t st;
    logic [1:0] q;
    logic [DW-1:0] div;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic nack;
    logic rfail;
    logic scl;
    logic sda_oe;
    logic aw_got;
    logic [3:0] awa;
    logic w_got;
    logic [10:0] wd;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sewt_hreg_t;

  sewt_hreg_t r;
  sewt_hreg_t next_r;
  logic sda_s;
  logic tick;

  // data line read back through a synchroniser
  sewt_sync #(.W(1)) sewt_sync_inst (
    .clk(clk),
    .resetn(resetn),
    .d(bus.sda),
    .q(sda_s)
  );

  // quarter-period enable
  assign tick = (r.div == DW'(QD - 1));

  // bus handshakes
  assign s_axi_awready = ~r.aw_got & ~r.bvalid;
  assign s_axi_wready = ~r.w_got & ~r.bvalid;
  assign s_axi_arready = ~r.rvalid;

  always_comb
  begin
    next_r = r;
    next_r.div = tick ? '0 : DW'(r.div + 1'b1);
    // write channel capture
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.w_got = 1'b1;
      next_r.wd = s_axi_wdata[10:0];
    end
    if (s_axi_bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    // command launch once address and data are both in
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = (r.awa == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
      if (r.awa == REG_CMD && r.st == H_IDLE)
      begin
        next_r.q = 2'h0;
        next_r.div = '0;
        next_r.bitn = 4'h0;
        next_r.sh = {r.wd[7:0], 1'b1}; // ninth bit released for acknowledge
        next_r.nack = 1'b0;
        next_r.rfail = 1'b0;
        unique case (sewt_op_t'(r.wd[CMD_OP_LSB+1:CMD_OP_LSB]))
          OP_START: next_r.st = H_START;
          OP_STOP: next_r.st = H_STOP;
          OP_BYTE: next_r.st = H_BIT;
          OP_RECOV: next_r.st = H_RECOV;
        endcase
      end
    end
    // read channel
    if (s_axi_rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = '0;
      next_r.rresp = RESP_OKAY;
      if (s_axi_araddr == REG_STATUS)
      begin
        next_r.rdata[ST_BUSY] = (r.st != H_IDLE);
        next_r.rdata[ST_NACK] = r.nack;
        next_r.rdata[ST_RFAIL] = r.rfail;
        next_r.rdata[ST_SDA] = sda_s;
      end
      else if (s_axi_araddr == REG_CMD)
        next_r.rdata[10:0] = r.wd;
      else
        next_r.rresp = RESP_SLVERR;
    end
    // line sequencer, one quarter per tick
    if (tick && r.st != H_IDLE)
    begin
      next_r.q = r.q + 2'h1;
      unique case (r.st)
        H_START:
        begin
          unique case (r.q)
            2'h0: begin next_r.scl = 1'b0; next_r.sda_oe = 1'b0; end
            2'h1: next_r.scl = 1'b1;
            2'h2: next_r.sda_oe = 1'b1;
            2'h3: begin next_r.scl = 1'b0; next_r.st = H_IDLE; end
          endcase
        end
        H_STOP:
        begin
          unique case (r.q)
            2'h0: begin next_r.scl = 1'b0; next_r.sda_oe = 1'b1; end
            2'h1: next_r.scl = 1'b1;
            2'h2: next_r.sda_oe = 1'b0;
            2'h3: next_r.st = H_IDLE;
          endcase
        end
        H_BIT:
        begin
          unique case (r.q)
            2'h0: next_r.sda_oe = ~r.sh[8];
            2'h1: next_r.scl = 1'b1;
            2'h2: if (r.bitn == 4'(WORD_BITS)) next_r.nack = sda_s;
            2'h3:
            begin
              next_r.scl = 1'b0;
              next_r.sh = {r.sh[7:0], 1'b1};
              next_r.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'(WORD_BITS))
                next_r.st = H_IDLE;
            end
          endcase
        end
        H_RECOV:
        begin
          unique case (r.q)
            2'h0: begin next_r.scl = 1'b0; next_r.sda_oe = 1'b0; end
            2'h1: next_r.scl = 1'b1;
            2'h2:
            if (sda_s)
            begin
              next_r.sda_oe = 1'b1;
              next_r.st = H_START;
            end
            2'h3:
            begin
              next_r.scl = 1'b0;
              next_r.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'(RECOV_CLOCKS - 1))
              begin
                next_r.rfail = 1'b1;
                next_r.st = H_IDLE;
              end
            end
          endcase
        end
        default: next_r.st = H_IDLE;
      endcase
    end
  end

  // state register, bus released after reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      r <= '0;
      r.scl <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign bus.scl = r.scl;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = r.sda_oe;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
endmodule

// File: verification/sewt_props.sv
// concurrent checks on the two-wire bus between master and target
`timescale 1ns/100ps
module sewt_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_t_o,
  input wire logic sda_t_oe
);
  logic scl_q;
  logic sda_q;
  logic in_frame;
  logic [3:0] nbit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // previous line levels, frame flag and clock count since start, wrapping to zero after the ninth clock
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      nbit <= 4'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda)
      begin
        in_frame <= 1'b1;
        nbit <= 4'h0;
      end
      else if (scl && scl_q && !sda_q && sda)
        in_frame <= 1'b0;
      else if (scl && !scl_q)
        nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
    end
  end
  // bus conditions and the acknowledge slot
  sequence stop_seq;
    scl && scl_q && !sda_q && sda;
  endsequence
  sequence ack_slot;
    scl && !scl_q && sda_t_oe;
  endsequence
  tgt_change_low_a: assert property ($changed(sda_t_oe) |-> !scl)
    else $error("target moved data while clock high");
  ack_ninth_a: assert property (ack_slot |-> nbit == 4'h8)
    else $error("acknowledge outside ninth clock");
  ack_hold_a: assert property ($rose(sda_t_oe) |-> (!scl) [*8])
    else $error("acknowledge not launched after clock fall");
  ack_release_a: assert property ($rose(sda_t_oe) |-> ##[1:200] !sda_t_oe)
    else $error("acknowledge never released");
  open_drain_a: assert property (!sda_t_o && !sda_m_o)
    else $error("data line driven high");
  frame_start_a: assert property ($fell(scl) |-> in_frame || sda)
    else $error("clocking without start and line low");
  stop_idle_a: assert property (stop_seq |-> scl [*8])
    else $error("clock not idle after stop");
  ack_whole_a: assert property (ack_slot |-> (sda_t_oe && scl) [*4])
    else $error("acknowledge dropped during high clock");
endmodule

// File: verification/sewt_tb.sv
// self-checking bench: master and target joined over the two-wire bus
`timescale 1ns/100ps
module sewt_tb;
  import sewt_pkg::*;
  localparam int PCY = 2000;
  logic clk, resetn, wp, idl, busy, prog_we, prog_id;
  logic [2:0] strap;
  logic [15:0] prog_addr;
  logic [7:0] prog_data, dva;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [24:0] pq[$];
  int err_total, checks, bcnt, lastb;
  assign dva = {DEV_ARRAY, strap, 1'b0};
  sewt_if bus_if();
  sewt_target #(.PROG_CYC(PCY)) sewt_target_inst (.clk(clk), .resetn(resetn), .bus(bus_if),
    .strap_address_inputs(strap), .write_protect(wp), .id_locked(idl), .busy(busy), .prog_we(prog_we),
    .prog_id(prog_id), .prog_addr(prog_addr), .prog_data(prog_data));
  sewt_master #(.QD(8)) sewt_master_inst (.clk(clk), .resetn(resetn), .bus(bus_if),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  sewt_props sewt_props_inst (.clk(clk), .resetn(resetn), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe), .sda_t_o(bus_if.sda_t_o), .sda_t_oe(bus_if.sda_t_oe));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // record programming pulses and each busy run length
  always @(posedge clk)
  begin
    if (prog_we === 1'b1)
      pq.push_back({prog_id, prog_addr, prog_data});
    if (busy === 1'b1)
      bcnt++;
    else if (bcnt != 0)
    begin
      lastb = bcnt;
      bcnt = 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // register write and read cycles
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    // one idle edge so a following request never re-raises bready in this step
    @(posedge clk);
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // one idle edge so back-to-back reads never drive rready twice at once
    @(posedge clk);
  endtask
  // one bus operation, then wait until the master is idle
  task automatic op(input sewt_op_t o, input logic [7:0] b, output logic [31:0] st);
    logic [1:0] rs;
    axw(REG_CMD, {22'h0, o, b});
    do
      axr(REG_STATUS, st, rs);
    while (st[ST_BUSY] !== 1'b0);
  endtask
  task automatic frame(input logic [7:0] b[$], output logic [7:0] nk);
    logic [31:0] st;
    nk = 8'h00;
    op(OP_START, 8'h00, st);
    for (int i = 0; i < b.size(); i++)
    begin
      op(OP_BYTE, b[i], st);
      nk[i] = st[ST_NACK];
    end
    op(OP_STOP, 8'h00, st);
  endtask
  task automatic drain();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < PCY + 50)
    begin
      @(posedge clk);
      i++;
    end
    chk(busy, 0);
    repeat (8) @(posedge clk);
  endtask
  task automatic pop(input logic [24:0] e);
    if (pq.size() == 0)
      chk(32'h1, 32'h0);
    else
      chk({7'h0, pq.pop_front()}, {7'h0, e});
  endtask
  // scenarios
  task automatic t_byte();
    logic [7:0] nk;
    logic [31:0] st;
    int tries;
    frame('{dva, 8'h12, 8'h34, 8'h5a}, nk);
    chk(nk, 32'h0);
    tries = 0;
    do
    begin
      op(OP_START, 8'h00, st);
      op(OP_BYTE, dva, st);
      tries++;
    end while (st[ST_NACK] !== 1'b0 && tries < 40);
    chk(st[ST_NACK], 0);
    op(OP_STOP, 8'h00, st);
    chk(tries > 1, 1);
    chk(busy, 0);
    drain();
    chk(lastb, PCY);
    pop({1'b0, 16'h1234, 8'h5a});
    chk(pq.size(), 0);
  endtask
  task automatic t_page();
    logic [7:0] nk;
    frame('{dva, 8'h12, 8'h7e, 8'ha1, 8'hb2, 8'hc3}, nk);
    chk(nk, 32'h0);
    drain();
    pop({1'b0, 16'h1200, 8'hc3});
    pop({1'b0, 16'h127e, 8'ha1});
    pop({1'b0, 16'h127f, 8'hb2});
    chk(pq.size(), 0);
  endtask
  task automatic t_strap();
    logic [7:0] nk;
    frame('{{DEV_ARRAY, ~strap, 1'b0}, 8'h12, 8'h34, 8'h5a}, nk);
    chk(nk, 32'hf);
    frame('{{DEV_ARRAY, strap, 1'b1}}, nk);
    chk(nk, 32'h0);
    drain();
    chk(pq.size(), 0);
  endtask
  task automatic t_wp();
    logic [7:0] nk;
    wp <= 1'b1;
    frame('{dva, 8'h22, 8'h10, 8'h3c}, nk);
    chk(nk, 32'h0);
    drain();
    chk(pq.size(), 0);
    wp <= 1'b0;
  endtask
  task automatic t_id();
    logic [7:0] nk;
    frame('{{DEV_ID, strap, 1'b0}, 8'hfb, 8'h05, 8'h77}, nk);
    chk(nk, 32'h0);
    drain();
    pop({1'b1, 16'hfb05, 8'h77});
    idl <= 1'b1;
    frame('{{DEV_ID, strap, 1'b0}, 8'hfb, 8'h06, 8'h78}, nk);
    chk(nk, 32'h8);
    drain();
    chk(pq.size(), 0);
    idl <= 1'b0;
  endtask
  task automatic t_regs();
    logic [31:0] st;
    logic [31:0] d;
    logic [1:0] rs;
    op(OP_RECOV, 8'h00, st);
    chk(st[ST_RFAIL], 0);
    chk(st[ST_SDA], 0);
    axr(REG_CMD, d, rs);
    chk(d[10:0], {OP_RECOV, 8'h00});
    axr(4'h8, d, rs);
    chk(rs, RESP_SLVERR);
    // unmapped write is answered with an error and launches nothing
    axw(4'h8, 32'h0);
    chk(bresp, RESP_SLVERR);
    op(OP_STOP, 8'h00, st);
    chk(st[ST_SDA], 1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #(8 * 90000);
    err_total++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    resetn = 1'b0;
    strap = 3'b101;
    wp = 1'b0;
    idl = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_byte();
    t_page();
    t_strap();
    t_wp();
    t_id();
    t_regs();
    report_and_stop();
  end
endmodule
